// >>> flash_prot_pkg.sv
// shared constants, types and carriers of the protected flash block
`default_nettype none
package flash_prot_pkg;
    localparam int FLASH_BYTES = 65536;
    localparam int BLOCK_BYTES = 1024;
    localparam int UNIT_BYTES = 2048;
    localparam int WORD_BYTES = 4;
    localparam int DATA_W = 32;
    localparam int WORD_ADDR_W = 14;
    localparam int WORDS = FLASH_BYTES / WORD_BYTES;
    localparam int BLOCK_WORDS = BLOCK_BYTES / WORD_BYTES;
    localparam int BLOCKS = FLASH_BYTES / BLOCK_BYTES;
    localparam int UNITS = FLASH_BYTES / UNIT_BYTES;
    localparam int BLOCK_LSB = 8;
    localparam int UNIT_LSB = 9;
    localparam int READ_LATENCY = 1;
    localparam int ERASE_CYCLES = 256;
    localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
    localparam logic [31:0] DENIED_WORD = 32'h0000_0000;
    localparam logic [7:0] WORD_IDX_RESET = 8'h00;

    typedef enum logic [1:0] {
        PROT_OPEN = 2'b00,
        PROT_READ_ONLY = 2'b01,
        PROT_EXEC_ONLY = 2'b10
    } prot_mode_t;

    typedef enum logic {
        OP_PROGRAM = 1'b0,
        OP_ERASE = 1'b1
    } op_t;

    typedef struct packed {
        logic valid;
        logic debug;
        logic [WORD_ADDR_W-1:0] addr;
    } rd_req_t;

    typedef struct packed {
        logic valid;
        logic denied;
        logic [DATA_W-1:0] data;
    } rd_rsp_t;

    typedef struct packed {
        logic valid;
        op_t op;
        logic [WORD_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic done;
        logic refused;
    } cmd_status_t;
endpackage
`default_nettype wire

// >>> flash_block_erase_protect.sv
// protected flash array with single-cycle reads, block erase and unit protection
//
// Contract
// - the array holds 64 KB split into 1-KB erase blocks, each erased without touching others.
// - a completed erase leaves every bit of every word of the block at one.
// - protection is applied per 2-KB unit made of two adjacent blocks, each unit independent.
// - each unit may be open, read-only or execute-only.
// - erase or program aimed at a read-only unit is refused and its contents stay unchanged.
// - erase or program aimed at an execute-only unit is refused and its contents stay unchanged.
// - execute-only units answer instruction fetches only and deny processor or debugger data reads.
// - every read completes in one clock cycle with no wait states.
`default_nettype none
module flash_block_erase_protect #(
    parameter int UNITS = flash_prot_pkg::UNITS,
    parameter int ERASE_CYCLES = flash_prot_pkg::ERASE_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // protection setting per unit
    input wire flash_prot_pkg::prot_mode_t [UNITS-1:0] prot_mode_in,
    // instruction fetch path
    input wire flash_prot_pkg::rd_req_t fetch_in,
    output flash_prot_pkg::rd_rsp_t fetch_out,
    // data and debugger read path
    input wire flash_prot_pkg::rd_req_t data_in,
    output flash_prot_pkg::rd_rsp_t data_out,
    // program and erase commands
    input wire flash_prot_pkg::cmd_t cmd_in,
    output logic cmd_ready_out,
    output flash_prot_pkg::cmd_status_t cmd_out
);
    // the erase walk and unit decode are sized from the package, so refuse other geometry
    if (UNITS != flash_prot_pkg::UNITS || ERASE_CYCLES != flash_prot_pkg::BLOCK_WORDS) begin
        $error("unsupported flash geometry");
    end

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_ERASE = 1'b1
    } state_t;

    localparam int AW = flash_prot_pkg::WORD_ADDR_W;
    localparam int DW = flash_prot_pkg::DATA_W;
    localparam int UW = AW - flash_prot_pkg::UNIT_LSB;
    localparam int BW = AW - flash_prot_pkg::BLOCK_LSB;

    // word storage; no reset, flash keeps contents
    logic [DW-1:0] mem [flash_prot_pkg::WORDS];

    state_t state;
    logic [BW-1:0] erase_block;
    logic [flash_prot_pkg::BLOCK_LSB-1:0] erase_idx;
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic [DW-1:0] mem_wdata;
    logic cmd_take;
    logic cmd_allowed;
    flash_prot_pkg::prot_mode_t cmd_mode;
    flash_prot_pkg::prot_mode_t data_mode;

    // unit and block of a word address
    function automatic logic [UW-1:0] unit_of(input logic [AW-1:0] a);
        return a[AW-1:flash_prot_pkg::UNIT_LSB];
    endfunction

    function automatic logic [BW-1:0] block_of(input logic [AW-1:0] a);
        return a[AW-1:flash_prot_pkg::BLOCK_LSB];
    endfunction

    function automatic flash_prot_pkg::prot_mode_t mode_of(
        input flash_prot_pkg::prot_mode_t [UNITS-1:0] m,
        input logic [AW-1:0] a
    );
        return m[unit_of(a)];
    endfunction

    assign cmd_mode = mode_of(prot_mode_in, cmd_in.addr);
    assign data_mode = mode_of(prot_mode_in, data_in.addr);
    // commands wait while an erase walks its block
    assign cmd_ready_out = (state == ST_IDLE);
    assign cmd_take = cmd_in.valid && cmd_ready_out;
    assign cmd_allowed = (cmd_mode == flash_prot_pkg::PROT_OPEN);

    // single write port shared by program and the erase walk
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = cmd_in.addr;
        mem_wdata = mem[cmd_in.addr] & cmd_in.wdata;
        if (state == ST_ERASE) begin
            mem_we = 1'b1;
            mem_waddr = {erase_block, erase_idx};
            mem_wdata = flash_prot_pkg::ERASED_WORD;
        end else if (cmd_take && cmd_allowed && cmd_in.op == flash_prot_pkg::OP_PROGRAM) begin
            // programming only clears bits, as real cells do
            mem_we = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // erase sequencer
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
            erase_block <= '0;
            erase_idx <= flash_prot_pkg::WORD_IDX_RESET;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cmd_take && cmd_allowed && cmd_in.op == flash_prot_pkg::OP_ERASE) begin
                        state <= ST_ERASE;
                        erase_block <= block_of(cmd_in.addr);
                        erase_idx <= flash_prot_pkg::WORD_IDX_RESET;
                    end
                end
                ST_ERASE: begin
                    erase_idx <= erase_idx + 1'b1;
                    if (erase_idx == '1) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // command status pulses
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            cmd_out <= '0;
        end else begin
            cmd_out.refused <= cmd_take && !cmd_allowed;
            cmd_out.done <= (cmd_take && cmd_allowed && cmd_in.op == flash_prot_pkg::OP_PROGRAM)
                || (state == ST_ERASE && erase_idx == '1);
        end
    end

    // fetch path: always served, one cycle
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            fetch_out <= '0;
        end else begin
            fetch_out.valid <= fetch_in.valid;
            fetch_out.denied <= 1'b0;
            fetch_out.data <= mem[fetch_in.addr];
        end
    end

    // data path: execute-only units read back as zero with a deny flag
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            data_out <= '0;
        end else begin
            data_out.valid <= data_in.valid;
            if (data_mode == flash_prot_pkg::PROT_EXEC_ONLY) begin
                data_out.denied <= data_in.valid;
                data_out.data <= flash_prot_pkg::DENIED_WORD;
            end else begin
                data_out.denied <= 1'b0;
                data_out.data <= mem[data_in.addr];
            end
        end
    end

    // helper: protection seen by the write port
    flash_prot_pkg::prot_mode_t wr_mode;
    logic [BW-1:0] held_block;
    assign wr_mode = mode_of(prot_mode_in, mem_waddr);

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            held_block <= '0;
        end else if (cmd_take) begin
            held_block <= block_of(cmd_in.addr);
        end
    end

    sequence s_erase_start;
        cmd_take && cmd_allowed && cmd_in.op == flash_prot_pkg::OP_ERASE;
    endsequence

    sequence s_erase_walk;
        (state == ST_ERASE && mem_we && mem_wdata == flash_prot_pkg::ERASED_WORD) [*8];
    endsequence

    AST_ERASE_WALK: assert property (@(posedge clock_in) disable iff (!nrst_in)
        s_erase_start |=> s_erase_walk)
        else $error("erase does not write ones");

    AST_ERASE_LENGTH: assert property (@(posedge clock_in) disable iff (!nrst_in)
        s_erase_start |-> ##257 (cmd_out.done && state == ST_IDLE))
        else $error("erase length wrong");

    AST_ERASE_LOCAL: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (state == ST_ERASE) |-> (block_of(mem_waddr) == held_block))
        else $error("erase left its block");

    AST_NO_PROT_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (mem_we && state == ST_IDLE) |-> (wr_mode == flash_prot_pkg::PROT_OPEN))
        else $error("write into protected unit");

    AST_RO_REFUSE: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (cmd_take && cmd_mode == flash_prot_pkg::PROT_READ_ONLY)
        |-> !mem_we ##1 (cmd_out.refused && !cmd_out.done && state == ST_IDLE))
        else $error("read-only unit not refused");

    AST_XO_REFUSE: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (cmd_take && cmd_mode == flash_prot_pkg::PROT_EXEC_ONLY)
        |-> !mem_we ##1 (cmd_out.refused && state == ST_IDLE))
        else $error("execute-only unit not refused");

    AST_XO_DENY: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (data_in.valid && data_mode == flash_prot_pkg::PROT_EXEC_ONLY)
        |=> (data_out.valid && data_out.denied && data_out.data == flash_prot_pkg::DENIED_WORD))
        else $error("execute-only data read not denied");

    AST_FETCH_ONE_CYCLE: assert property (@(posedge clock_in) disable iff (!nrst_in)
        fetch_in.valid |=> (fetch_out.valid && !fetch_out.denied))
        else $error("fetch not answered in one cycle");

    AST_OPEN_READ: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (data_in.valid && data_mode != flash_prot_pkg::PROT_EXEC_ONLY && !mem_we)
        |=> (data_out.valid && !data_out.denied && data_out.data == $past(mem[data_in.addr])))
        else $error("open data read wrong");

    AST_OPEN_ACCEPT: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (cmd_take && cmd_allowed) |=> (!cmd_out.refused && (cmd_out.done || state == ST_ERASE)))
        else $error("open command not accepted");
endmodule
`default_nettype wire

// >>> cpu_side_model.sv
// processor fetch, data, debugger and flash command side model
`default_nettype none
module cpu_side_model (
    // clock
    input wire logic clock_in,
    // answers from the flash
    input wire flash_prot_pkg::rd_rsp_t fetch_rsp_in,
    input wire flash_prot_pkg::rd_rsp_t data_rsp_in,
    input wire logic cmd_ready_in,
    input wire flash_prot_pkg::cmd_status_t cmd_status_in,
    // requests towards the flash
    output var flash_prot_pkg::rd_req_t fetch_out,
    output var flash_prot_pkg::rd_req_t data_out,
    output var flash_prot_pkg::cmd_t cmd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fetch_out = '0;
        data_out = '0;
        cmd_out = '0;
    end
    // released lines show inverted values so a stale address is never reused silently
    task automatic read(input logic f, input logic dbg, input logic [13:0] a,
                        output flash_prot_pkg::rd_rsp_t rsp, output logic stale);
        @(negedge clock_in);
        if (f) fetch_out <= {1'b1, dbg, a};
        else data_out <= {1'b1, dbg, a};
        @(negedge clock_in);
        rsp = f ? fetch_rsp_in : data_rsp_in;
        if (f) fetch_out <= {1'b0, dbg, ~a};
        else data_out <= {1'b0, dbg, ~a};
        @(negedge clock_in);
        stale = f ? fetch_rsp_in.valid : data_rsp_in.valid;
    endtask
    // request held until an edge samples ready high
    task automatic command(input flash_prot_pkg::op_t op, input logic [13:0] a,
                           input logic [31:0] d, output flash_prot_pkg::cmd_status_t st,
                           output int waits);
        @(negedge clock_in);
        cmd_out <= {1'b1, op, a, d};
        do @(posedge clock_in); while (cmd_ready_in !== 1'b1);
        @(negedge clock_in);
        cmd_out <= {1'b0, op, ~a, ~d};
        waits = 0;
        st = cmd_status_in;
        while (st === 2'b00 && waits < 300) begin
            @(negedge clock_in);
            waits++;
            st = cmd_status_in;
        end
    endtask
endmodule
`default_nettype wire

// >>> flash_block_erase_protect_tb.sv
// self-checking bench for the protected flash block
`default_nettype none
module flash_block_erase_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in;
    logic nrst_in;
    flash_prot_pkg::prot_mode_t [flash_prot_pkg::UNITS-1:0] prot_mode;
    flash_prot_pkg::rd_req_t fetch_req;
    flash_prot_pkg::rd_req_t data_req;
    flash_prot_pkg::rd_rsp_t fetch_rsp;
    flash_prot_pkg::rd_rsp_t data_rsp;
    flash_prot_pkg::cmd_t cmd;
    flash_prot_pkg::cmd_status_t cmd_st;
    logic cmd_ready;
    int fail_count = 0;
    int checked = 0;
    flash_block_erase_protect uut (.clock_in(clock_in), .nrst_in(nrst_in),
        .prot_mode_in(prot_mode), .fetch_in(fetch_req), .fetch_out(fetch_rsp),
        .data_in(data_req), .data_out(data_rsp), .cmd_in(cmd),
        .cmd_ready_out(cmd_ready), .cmd_out(cmd_st));
    cpu_side_model cpu (.clock_in(clock_in), .fetch_rsp_in(fetch_rsp),
        .data_rsp_in(data_rsp), .cmd_ready_in(cmd_ready), .cmd_status_in(cmd_st),
        .fetch_out(fetch_req), .data_out(data_req), .cmd_out(cmd));
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic rd(input logic f, input logic dbg, input logic [13:0] a,
                      input logic [31:0] exp_d, input logic exp_den);
        flash_prot_pkg::rd_rsp_t r;
        logic stale;
        cpu.read(f, dbg, a, r, stale);
        check(32'(r.valid), 32'h0000_0001, "answer one cycle after request");
        check(32'(stale), 32'h0000_0000, "answer stands one cycle");
        check(32'(r.denied), 32'(exp_den), "denied flag");
        check(r.data, exp_d, "read data");
    endtask
    // erase answers after the full sweep, program and refusals at once
    task automatic cm(input flash_prot_pkg::op_t op, input logic [13:0] a,
                      input logic [31:0] d, input logic exp_ref);
        flash_prot_pkg::cmd_status_t st;
        int w;
        cpu.command(op, a, d, st, w);
        check(32'(st), exp_ref ? 32'h0000_0001 : 32'h0000_0002, "command status");
        check(32'(w), (op == flash_prot_pkg::OP_ERASE && !exp_ref) ?
              32'(flash_prot_pkg::ERASE_CYCLES) : 32'h0000_0000, "status delay");
    endtask
    task automatic t_erase();
        cm(flash_prot_pkg::OP_ERASE, 14'h0000, 32'h0000_0000, 1'b0);
        cm(flash_prot_pkg::OP_ERASE, 14'h0100, 32'h0000_0000, 1'b0);
        cm(flash_prot_pkg::OP_ERASE, 14'h02ff, 32'h0000_0000, 1'b0);
        rd(1'b1, 1'b0, 14'h0000, flash_prot_pkg::ERASED_WORD, 1'b0);
        rd(1'b0, 1'b0, 14'h00ff, flash_prot_pkg::ERASED_WORD, 1'b0);
        rd(1'b0, 1'b1, 14'h0100, flash_prot_pkg::ERASED_WORD, 1'b0);
        rd(1'b1, 1'b0, 14'h02ff, flash_prot_pkg::ERASED_WORD, 1'b0);
        $display("test erase done");
    endtask
    task automatic t_program();
        cm(flash_prot_pkg::OP_PROGRAM, 14'h0005, 32'h1234_5678, 1'b0);
        cm(flash_prot_pkg::OP_PROGRAM, 14'h0005, 32'hffff_00ff, 1'b0);
        rd(1'b0, 1'b0, 14'h0005, 32'h1234_0078, 1'b0);
        rd(1'b1, 1'b0, 14'h0005, 32'h1234_0078, 1'b0);
        cm(flash_prot_pkg::OP_ERASE, 14'h0100, 32'h0000_0000, 1'b0);
        rd(1'b0, 1'b0, 14'h0005, 32'h1234_0078, 1'b0);
        $display("test program done");
    endtask
    // unit 1 stays open while unit 0 is locked
    task automatic t_read_only();
        @(negedge clock_in);
        prot_mode[0] = flash_prot_pkg::PROT_READ_ONLY;
        cm(flash_prot_pkg::OP_PROGRAM, 14'h0005, 32'h0000_0000, 1'b1);
        cm(flash_prot_pkg::OP_ERASE, 14'h0000, 32'h0000_0000, 1'b1);
        cm(flash_prot_pkg::OP_ERASE, 14'h0180, 32'h0000_0000, 1'b1);
        rd(1'b0, 1'b1, 14'h0005, 32'h1234_0078, 1'b0);
        cm(flash_prot_pkg::OP_PROGRAM, 14'h0200, 32'ha5a5_a5a5, 1'b0);
        rd(1'b0, 1'b0, 14'h0200, 32'ha5a5_a5a5, 1'b0);
        $display("test read-only done");
    endtask
    task automatic t_exec_only();
        @(negedge clock_in);
        prot_mode[0] = flash_prot_pkg::PROT_EXEC_ONLY;
        cm(flash_prot_pkg::OP_PROGRAM, 14'h0005, 32'h0000_0000, 1'b1);
        cm(flash_prot_pkg::OP_ERASE, 14'h0100, 32'h0000_0000, 1'b1);
        rd(1'b1, 1'b0, 14'h0005, 32'h1234_0078, 1'b0);
        rd(1'b0, 1'b0, 14'h0005, flash_prot_pkg::DENIED_WORD, 1'b1);
        rd(1'b0, 1'b1, 14'h01ff, flash_prot_pkg::DENIED_WORD, 1'b1);
        rd(1'b0, 1'b1, 14'h0200, 32'ha5a5_a5a5, 1'b0);
        // the unused code refuses writes but still reads back
        prot_mode[1] = flash_prot_pkg::prot_mode_t'(2'b11);
        cm(flash_prot_pkg::OP_PROGRAM, 14'h0200, 32'h0000_0000, 1'b1);
        rd(1'b0, 1'b0, 14'h0200, 32'ha5a5_a5a5, 1'b0);
        $display("test exec-only done");
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end
    initial begin
        nrst_in = 1'b0;
        prot_mode = '0;
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        nrst_in = 1'b1;
        check(32'(cmd_ready), 32'h0000_0001, "ready after reset");
        t_erase();
        t_program();
        t_read_only();
        t_exec_only();
        close_out();
    end
endmodule
`default_nettype wire
